//--- core/adcsq_top.sv
// conversion sequencer around an 8-bit successive-approximation converter
// assumes a single 20 MHz clock, an AXI4-Lite master, and an analog front
// end that compares the sampled input with o_dac_code on i_cmp_above
`timescale 1ns/10ps

// Function
// - conversions run whatever the channel field and pin directions hold
// - port data read returns zero on every pin configured analog
// - clock select 00/01/10 gives 2/8/32 oscillator periods, 11 the rc clock
// - rc selection takes the bit period from the private rc oscillator
// - clearing start mid conversion aborts it and leaves the result untouched
// - after an abort wait two bit periods, then acquire the selected channel
// - completion loads result, clears start/busy and sets the done flag
// - conversion lasts two overhead bit periods plus one per resolved bit
// - a mid conversion rate change continues at the new rate
// - with rc selected, start waits one instruction cycle
// - rc conversions run through sleep; wake only if interrupt enabled
// - sleep with a divided clock aborts and powers down, on bit stays set
// - converter off means lowest current and no conversion activity
// - channel field routes analog input 0 to 3 to the sampler
// - after completion hold off sampling for two bit periods
// - reset turns the converter off and aborts; result not cleared
module adcsq_top (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   input  wire logic        i_sleep,
   output logic             o_wake,
   input  wire logic        i_rc_osc,
   input  wire logic        i_cmp_above,
   output logic [1:0]       o_channel,
   output logic             o_sample,
   output logic             o_powered,
   output logic             o_vref_ext,
   output logic [7:0]       o_dac_code,
   input  wire logic [4:0]  i_pin_in,
   output logic [4:0]       o_pin_out,
   output logic [4:0]       o_pin_oe
);

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == adcsq_pkg::OFS_CTRL)   ||
                  (a == adcsq_pkg::OFS_PCFG)   ||
                  (a == adcsq_pkg::OFS_RESULT) ||
                  (a == adcsq_pkg::OFS_DIR)    ||
                  (a == adcsq_pkg::OFS_PORT)   ||
                  (a == adcsq_pkg::OFS_IRQEN);
   endfunction

   // analog pins per port configuration; ra3 as reference also reads 0
   function automatic logic [4:0] analog_mask(input logic [1:0] cfg);
      unique case (cfg)
         2'h0: analog_mask = 5'h0f;
         2'h1: analog_mask = 5'h0f;
         2'h2: analog_mask = 5'h00;
         2'h3: analog_mask = 5'h03;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   adcsq_pkg::adcsq_ctrl_t  ctrl;
   adcsq_pkg::adcsq_ctrl_t  next_ctrl;
   adcsq_pkg::adcsq_state_t state;
   adcsq_pkg::adcsq_state_t next_state;
   logic [3:0]  cnt;
   logic [3:0]  next_cnt;
   logic [7:0]  sar;
   logic [7:0]  next_sar;
   logic [7:0]  result;
   logic [1:0]  pcfg;
   logic [4:0]  dir;
   logic [4:0]  port_lat;
   logic        irq_en;
   logic        bvalid;
   logic [1:0]  bresp;
   logic        rvalid;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic [4:0]  pin_s1;
   logic [4:0]  pin_s2;
   logic [1:0]  cmp_s;
   logic [2:0]  rc_s;
   logic        restart;
   logic        complete;
   logic        abort;
   logic        halt;
   logic        tick;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
         cmp_s  <= 2'h0;
         rc_s   <= 3'h0;
      end else begin
         pin_s1 <= i_pin_in;
         pin_s2 <= pin_s1;
         cmp_s  <= {cmp_s[0], i_cmp_above};
         rc_s   <= {rc_s[1:0], i_rc_osc};
      end
   end

   wire rc_rise = rc_s[1] & ~rc_s[2];
   wire cmp_hi  = cmp_s[1];

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire wr_take  = i_awvalid & i_wvalid & ~bvalid;
   wire wr_map   = is_mapped(i_awaddr);
   wire wr_en    = wr_take & wr_map & i_wstrb[0];
   wire wr_ctrl  = wr_en & (i_awaddr == adcsq_pkg::OFS_CTRL);
   wire wr_pcfg  = wr_en & (i_awaddr == adcsq_pkg::OFS_PCFG);
   wire wr_res   = wr_en & (i_awaddr == adcsq_pkg::OFS_RESULT);
   wire wr_dir   = wr_en & (i_awaddr == adcsq_pkg::OFS_DIR);
   wire wr_port  = wr_en & (i_awaddr == adcsq_pkg::OFS_PORT);
   wire wr_irq   = wr_en & (i_awaddr == adcsq_pkg::OFS_IRQEN);
   wire rd_take  = i_arvalid & ~rvalid;
   wire rd_map   = is_mapped(i_araddr);
   wire [4:0] port_view = pin_s2 & ~analog_mask(pcfg);
   wire [7:0] wbyte = i_wdata[7:0];

   wire [31:0] rd_word =
      (i_araddr == adcsq_pkg::OFS_CTRL)   ? {24'h000000, ctrl} :
      (i_araddr == adcsq_pkg::OFS_PCFG)   ? {30'h00000000, pcfg} :
      (i_araddr == adcsq_pkg::OFS_RESULT) ? {24'h000000, result} :
      (i_araddr == adcsq_pkg::OFS_DIR)    ? {27'h0000000, dir} :
      (i_araddr == adcsq_pkg::OFS_PORT)   ? {27'h0000000, port_view} :
      (i_araddr == adcsq_pkg::OFS_IRQEN)  ? {31'h00000000, irq_en} :
      32'h00000000;

   assign o_awready = wr_take;
   assign o_wready  = wr_take;
   assign o_bvalid  = bvalid;
   assign o_bresp   = bresp;
   assign o_arready = ~rvalid;
   assign o_rvalid  = rvalid;
   assign o_rdata   = rdata;
   assign o_rresp   = rresp;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bvalid <= 1'b0;
         bresp  <= adcsq_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= adcsq_pkg::RESP_OKAY;
      end else begin
         if (wr_take) begin
            bvalid <= 1'b1;
            bresp  <= wr_map ? adcsq_pkg::RESP_OKAY : adcsq_pkg::RESP_SLVERR;
         end else if (i_bready) begin
            bvalid <= 1'b0;
         end
         if (rd_take) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_map ? adcsq_pkg::RESP_OKAY : adcsq_pkg::RESP_SLVERR;
         end else if (i_rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   wire rc_sel  = (ctrl.clk_sel == adcsq_pkg::CS_RC);
   // with a divided clock, sleep powers the converter down
   wire powered = ctrl.on & ~(i_sleep & ~rc_sel);
   wire busy    = (state == adcsq_pkg::ST_DLY) | (state == adcsq_pkg::ST_CNV);
   wire resolve = (cnt >= adcsq_pkg::OVH_TAD);
   wire [7:0] trial = (state == adcsq_pkg::ST_CNV && resolve) ?
                      (8'h80 >> (cnt - adcsq_pkg::OVH_TAD)) : 8'h00;
   wire [7:0] resolved = cmp_hi ? (sar | trial) : sar;

   adcsq_tick u_tick (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_sel     (ctrl.clk_sel),
      .i_restart (restart),
      .i_rc_rise (rc_rise),
      .o_tick    (tick)
   );

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_sar   = sar;
      restart    = 1'b0;
      complete   = 1'b0;
      abort      = 1'b0;
      halt       = 1'b0;
      unique case (state)
         adcsq_pkg::ST_ACQ: begin
            // neither the channel nor pin directions gate a start
            if (powered && ctrl.go) begin
               next_cnt = 4'h0;
               next_sar = 8'h00;
               if (rc_sel) begin
                  next_state = adcsq_pkg::ST_DLY;
               end else begin
                  next_state = adcsq_pkg::ST_CNV;
                  restart    = 1'b1;
               end
            end
         end
         adcsq_pkg::ST_DLY: begin
            next_cnt = cnt + 4'h1;
            if (cnt == adcsq_pkg::INSTR_CYC - 4'h1) begin
               next_state = adcsq_pkg::ST_CNV;
               next_cnt   = 4'h0;
               restart    = 1'b1;
            end
         end
         adcsq_pkg::ST_CNV: begin
            if (tick) begin
               next_cnt = cnt + 4'h1;
               next_sar = resolved;
               if (cnt == adcsq_pkg::LAST_TAD) begin
                  complete   = 1'b1;
                  next_state = adcsq_pkg::ST_REC;
                  next_cnt   = 4'h0;
                  restart    = 1'b1;
               end
            end
         end
         adcsq_pkg::ST_REC: begin
            if (tick) begin
               next_cnt = cnt + 4'h1;
               if (cnt == adcsq_pkg::REC_TAD - 4'h1) begin
                  next_state = adcsq_pkg::ST_ACQ;
                  next_cnt   = 4'h0;
               end
            end
         end
      endcase
      if (!powered && state != adcsq_pkg::ST_ACQ) begin
         halt       = busy;
         complete   = 1'b0;
         next_state = adcsq_pkg::ST_ACQ;
         next_cnt   = 4'h0;
      end else if (busy && !ctrl.go) begin
         abort      = 1'b1;
         complete   = 1'b0;
         next_state = adcsq_pkg::ST_REC;
         next_cnt   = 4'h0;
         restart    = 1'b1;
      end
   end

   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl      = adcsq_pkg::adcsq_ctrl_t'(wbyte);
         // start only counts once the converter was already on
         next_ctrl.go   = wbyte[2] & ctrl.on;
      end
      if (complete || halt) begin
         next_ctrl.go   = 1'b0;
      end
      if (complete) begin
         next_ctrl.done = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= adcsq_pkg::ST_ACQ;
         cnt   <= 4'h0;
         sar   <= 8'h00;
         ctrl  <= adcsq_pkg::adcsq_ctrl_t'(adcsq_pkg::CTRL_RST);
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         sar   <= next_sar;
         ctrl  <= next_ctrl;
      end
   end

   // no reset: power-on leaves the result undefined
   always_ff @(posedge i_clk_sys) begin
      if (complete) begin
         result <= resolved;
      end else if (wr_res) begin
         result <= wbyte;
      end
   end

   // ----------------------------------------------------------------
   // port and configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pcfg     <= adcsq_pkg::PCFG_RST;
         dir      <= adcsq_pkg::DIR_RST;
         port_lat <= adcsq_pkg::PORT_RST;
         irq_en   <= 1'b0;
      end else begin
         if (wr_pcfg) begin
            pcfg <= wbyte[1:0];
         end
         if (wr_dir) begin
            dir <= wbyte[4:0];
         end
         if (wr_port) begin
            port_lat <= wbyte[4:0];
         end
         if (wr_irq) begin
            irq_en <= wbyte[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_channel  = ctrl.chan;
   // the capacitor stays off the channel while recovering
   assign o_sample   = powered & (state == adcsq_pkg::ST_ACQ);
   assign o_powered  = powered;
   assign o_vref_ext = (pcfg == 2'h1);
   assign o_dac_code = sar | trial;
   // wake is a level; the core decides whether it is asleep
   assign o_wake     = ctrl.done & irq_en;
   assign o_pin_out  = port_lat;
   assign o_pin_oe   = ~dir;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   done_sets_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      complete |=> ctrl.done && !ctrl.go && state == adcsq_pkg::ST_REC)
      else $error("completion did not set flag");

   abort_keeps_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (abort && !wr_res) |=> $stable(result))
      else $error("abort changed the result");

   abort_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (abort && powered) |=> state == adcsq_pkg::ST_REC && cnt == 4'h0)
      else $error("abort skipped recovery");

   rec_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == adcsq_pkg::ST_REC && cnt == 4'h0 && tick && powered) |=>
      state == adcsq_pkg::ST_REC && !o_sample)
      else $error("recovery shorter than two periods");

   off_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !ctrl.on |-> !o_sample && !o_powered && !complete)
      else $error("converter active while off");

   port_mask_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (rd_take && i_araddr == adcsq_pkg::OFS_PORT) |=>
      (o_rdata[4:0] & analog_mask(pcfg)) == 5'h00)
      else $error("analog pin read as one");

   sleep_kill_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (busy && i_sleep && !rc_sel && ctrl.on && !wr_ctrl) |=>
      state == adcsq_pkg::ST_ACQ && ctrl.on && !ctrl.go)
      else $error("sleep did not abort");

   rc_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == adcsq_pkg::ST_ACQ && ctrl.go && powered && rc_sel) |=>
      state == adcsq_pkg::ST_DLY)
      else $error("rc start not delayed");

   conv_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      complete |-> cnt == adcsq_pkg::LAST_TAD && tick)
      else $error("conversion length wrong");

endmodule

//--- core/adcsq_pkg.sv
// package of the conversion sequencer: offsets, reset values, counts, types
// assumes a 20 MHz core clock and 32-bit AXI4-Lite register access
package adcsq_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_NS    = 50;
   localparam int unsigned INSTR_NS  = 200;
   localparam logic [3:0]  INSTR_CYC = 4'(INSTR_NS / CLK_NS);
   localparam logic [3:0]  OVH_TAD   = 4'h2;
   localparam logic [3:0]  LAST_TAD  = 4'h9;
   localparam logic [3:0]  REC_TAD   = 4'h2;
   localparam logic [4:0]  DIV2_TERM  = 5'h01;
   localparam logic [4:0]  DIV8_TERM  = 5'h07;
   localparam logic [4:0]  DIV32_TERM = 5'h1f;

   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PCFG   = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_DIR    = 8'h0c;
   localparam logic [7:0] OFS_PORT   = 8'h10;
   localparam logic [7:0] OFS_IRQEN  = 8'h14;

   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [1:0] PCFG_RST  = 2'h0;
   localparam logic [4:0] DIR_RST   = 5'h1f;
   localparam logic [4:0] PORT_RST  = 5'h00;
   localparam logic [1:0] CS_DIV2   = 2'h0;
   localparam logic [1:0] CS_DIV8   = 2'h1;
   localparam logic [1:0] CS_DIV32  = 2'h2;
   localparam logic [1:0] CS_RC     = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] clk_sel;
      logic       spare;
      logic [1:0] chan;
      logic       go;
      logic       done;
      logic       on;
   } adcsq_ctrl_t;

   typedef enum logic [1:0] {
      ST_ACQ = 2'b00,
      ST_DLY = 2'b01,
      ST_CNV = 2'b11,
      ST_REC = 2'b10
   } adcsq_state_t;

endpackage

//--- core/adcsq_tick.sv
// bit-period generator of the conversion sequencer
// assumes the rc edge input is already synchronised to i_clk_sys
`timescale 1ns/10ps
module adcsq_tick (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic [1:0] i_sel,
   input  wire logic       i_restart,
   input  wire logic       i_rc_rise,
   output logic            o_tick
);

   logic [4:0] cnt;
   logic [4:0] term;
   logic       div_hit;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   // the divisor follows the select at once, so a rate change mid
   // conversion simply continues at the new rate
   assign term = (i_sel == adcsq_pkg::CS_DIV2) ? adcsq_pkg::DIV2_TERM :
                 (i_sel == adcsq_pkg::CS_DIV8) ? adcsq_pkg::DIV8_TERM :
                 adcsq_pkg::DIV32_TERM;
   assign div_hit = (cnt == term);
   assign o_tick  = (i_sel == adcsq_pkg::CS_RC) ? i_rc_rise :
                    div_hit;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 5'h00;
      end else if (i_restart || div_hit) begin
         cnt <= 5'h00;
      end else begin
         cnt <= cnt + 5'h01;
      end
   end

   div2_rate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_tick && i_sel == adcsq_pkg::CS_DIV2) ##1
      (i_sel == adcsq_pkg::CS_DIV2 && !i_restart) ##1
      (i_sel == adcsq_pkg::CS_DIV2) |-> o_tick)
      else $error("divide by two tick missing");

   div2_gap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_tick && i_sel == 2'h0 && !i_restart) |=> !o_tick)
      else $error("divide by two tick too early");

endmodule

//--- bench/adcsq_afe.sv
// analog side model: comparator, private rc oscillator, port pins
// assumes the converter trials o_dac_code on the channel o_channel picks
`timescale 1ns/10ps
module adcsq_afe #(
   parameter logic [31:0] VIN = 32'h00000000
) (
   input  wire logic       i_powered,
   input  wire logic [1:0] i_channel,
   input  wire logic [7:0] i_dac_code,
   input  wire logic [4:0] i_pin_out,
   input  wire logic [4:0] i_pin_oe,
   output logic            o_cmp_above,
   output logic            o_rc_osc,
   output logic [4:0]      o_pin_in
);
   // ----
   // analog levels
   // ----
   logic [7:0] vin;

   assign vin = VIN[{i_channel, 3'h0} +: 8];
   // high keeps the trial bit
   assign o_cmp_above = vin > i_dac_code;
   // released pins float to the pull-up level
   assign o_pin_in = (i_pin_oe & i_pin_out) | ~i_pin_oe;

   // about 4 us period; stands still while unpowered
   initial o_rc_osc = 1'b0;
   always begin
      #2000;
      o_rc_osc = i_powered ? ~o_rc_osc : 1'b0;
   end
endmodule

//--- bench/tb.sv
// self-checking bench of the conversion sequencer
// assumes the analog model of adcsq_afe.sv on the far side
`timescale 1ns/10ps
module tb;
   // ----
   // signals
   // ----
   // divide by two is below the minimum bit period at 20 MHz, so channel 0
   // sits at zero, the one code that needs no settled comparator
   localparam logic [31:0] VIN   = 32'h1fc08000;
   localparam logic [19:0] PMASK = {5'h1c, 5'h1f, 5'h10, 5'h10};
   logic        i_clk_sys, i_rst_n, i_awvalid, i_wvalid, i_bready;
   logic        i_arvalid, i_rready, i_sleep, i_rc_osc, i_cmp_above;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic        o_wake, o_sample, o_powered, o_vref_ext;
   logic [7:0]  i_awaddr, i_araddr, o_dac_code;
   logic [31:0] i_wdata, o_rdata, rd, run = 32'h0, last_run = 32'h0;
   logic [3:0]  i_wstrb;
   logic [1:0]  o_bresp, o_rresp, o_channel, rs;
   logic [4:0]  i_pin_in, o_pin_out, o_pin_oe;
   int          bad_count = 0, checked = 0, cyc = 0, nw;

   adcsq_top adcsq_top_inst (
      .i_clk_sys, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr,
      .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
      .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
      .i_rready, .o_rdata, .o_rresp, .i_sleep, .o_wake, .i_rc_osc,
      .i_cmp_above, .o_channel, .o_sample, .o_powered, .o_vref_ext,
      .o_dac_code, .i_pin_in, .o_pin_out, .o_pin_oe
   );
   adcsq_afe #(.VIN(VIN)) adcsq_afe_inst (
      .i_powered(o_powered), .i_channel(o_channel),
      .i_dac_code(o_dac_code), .i_pin_out(o_pin_out),
      .i_pin_oe(o_pin_oe), .o_cmp_above(i_cmp_above),
      .o_rc_osc(i_rc_osc), .o_pin_in(i_pin_in)
   );

   initial i_clk_sys = 1'b0;
   always #25 i_clk_sys = ~i_clk_sys;

   // length of each stretch with the sampler disconnected
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (o_powered && !o_sample) begin
         run <= run + 32'h1;
      end else if (run != 32'h0) begin
         last_run <= run;
         run <= 32'h0;
      end
      if (cyc == 40000) begin
         bad_count = bad_count + 1;
         tally_and_finish();
      end
   end

   // ----
   // tasks
   // ----
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      do @(posedge i_clk_sys); while (o_awready !== 1'b1);
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      i_bready <= 1'b1;
      do @(posedge i_clk_sys); while (o_bvalid !== 1'b1);
      rs = o_bresp;
      i_bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge i_clk_sys);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do @(posedge i_clk_sys); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      i_rready <= 1'b1;
      do @(posedge i_clk_sys); while (o_rvalid !== 1'b1);
      rd = o_rdata;
      rs = o_rresp;
      i_rready <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd_reg(a);
      chk_val(rd, exp);
   endtask

   // cycles until the sampler reconnects, bounded
   task automatic wait_smp();
      for (nw = 0; nw < 100 && o_sample !== 1'b1; nw++) begin
         @(posedge i_clk_sys);
      end
      repeat (2) @(posedge i_clk_sys);
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] s, input logic [1:0] c,
                                       input logic g);
      return {24'h0, s, 1'b0, c, g, 2'h1};
   endfunction

   // successive approximation, keeping a bit while the input stays above
   function automatic logic [31:0] sar(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         if (v > (r | (8'h01 << b))) r = r | (8'h01 << b);
      end
      return {24'h0, r};
   endfunction

   task automatic tally_and_finish();
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----
   // tests
   // ----
   initial begin
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      {i_awaddr, i_araddr, i_wdata} = 48'h0;
      {i_sleep, i_rst_n, i_wstrb} = 6'h0f;
      repeat (10) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rdchk(adcsq_pkg::OFS_CTRL, 32'h0);
      rdchk(adcsq_pkg::OFS_DIR, 32'h1f);
      rdchk(8'h18, 32'h0);
      chk_val(32'(rs), 32'(adcsq_pkg::RESP_SLVERR));
      wr(8'h18, 32'h0);
      chk_val(32'(rs), 32'(adcsq_pkg::RESP_SLVERR));
      for (int p = 0; p < 4; p++) begin
         wr(adcsq_pkg::OFS_PCFG, 32'(p));
         chk_val(32'(o_vref_ext), 32'(p == 1));
         rdchk(adcsq_pkg::OFS_PORT, {27'h0, PMASK[5*p +: 5]});
      end
      wr(adcsq_pkg::OFS_PCFG, 32'h0);
      // pins left driving: conversions must not care
      wr(adcsq_pkg::OFS_DIR, 32'h0);
      chk_val(32'(o_pin_oe), 32'h1f);
      wr(adcsq_pkg::OFS_PORT, 32'h15);
      chk_val(32'(o_pin_out), 32'h15);
      rdchk(adcsq_pkg::OFS_PORT, 32'h10);
      wr(adcsq_pkg::OFS_IRQEN, 32'h1);
      // divided bit periods used here stay at or under 1.6 us
      for (int s = 0; s < 4; s++) begin
         wr(adcsq_pkg::OFS_CTRL, ctl(2'(s), 2'(s), 1'b0));
         chk_val(32'(o_channel), 32'(s));
         wr(adcsq_pkg::OFS_CTRL, ctl(2'(s), 2'(s), 1'b1));
         if (s == 3) begin
            // rc is kept for the sleeping conversion only
            i_sleep <= 1'b1;
            for (int i = 0; i < 3000 && o_wake !== 1'b1; i++) begin
               @(posedge i_clk_sys);
            end
            chk_val(32'(o_wake), 32'h1);
            i_sleep <= 1'b0;
         end
         for (int i = 0; i < 600; i++) begin
            rd_reg(adcsq_pkg::OFS_CTRL);
            if (rd[2] === 1'b0) break;
         end
         chk_val(rd, ctl(2'(s), 2'(s), 1'b0) | 32'h2);
         rdchk(adcsq_pkg::OFS_RESULT, sar(VIN[8*s +: 8]));
         wait_smp();
         if (s < 3) begin
            nw = 24 << (2 * s);
            chk_val(32'(last_run >= nw - 2 && last_run <= nw + 8),
                    32'h1);
         end
      end
      wr(adcsq_pkg::OFS_DIR, 32'h1f);
      wr(adcsq_pkg::OFS_RESULT, 32'ha5);
      rdchk(adcsq_pkg::OFS_RESULT, 32'ha5);
      // clearing start mid conversion aborts it and keeps the result
      wr(adcsq_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 1'b1));
      repeat (20) @(posedge i_clk_sys);
      wr(adcsq_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 1'b0));
      wait_smp();
      chk_val(32'(nw >= 12 && nw <= 18), 32'h1);
      rdchk(adcsq_pkg::OFS_RESULT, 32'ha5);
      rdchk(adcsq_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 1'b0));
      wr(adcsq_pkg::OFS_CTRL, ctl(2'h0, 2'h1, 1'b1));
      repeat (6) @(posedge i_clk_sys);
      i_sleep <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      chk_val(32'(o_powered), 32'h0);
      rdchk(adcsq_pkg::OFS_CTRL, ctl(2'h0, 2'h1, 1'b0));
      i_sleep <= 1'b0;
      wr(adcsq_pkg::OFS_CTRL, 32'h0);
      repeat (4) @(posedge i_clk_sys);
      chk_val({30'h0, o_powered, o_sample}, 32'h0);
      wr(adcsq_pkg::OFS_CTRL, ctl(2'h2, 2'h3, 1'b1));
      rdchk(adcsq_pkg::OFS_CTRL, ctl(2'h2, 2'h3, 1'b0));
      wr(adcsq_pkg::OFS_CTRL, ctl(2'h2, 2'h3, 1'b1));
      repeat (10) @(posedge i_clk_sys);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rdchk(adcsq_pkg::OFS_CTRL, 32'h0);
      rdchk(adcsq_pkg::OFS_RESULT, 32'ha5);
      tally_and_finish();
   end
endmodule
